/* File: spwr_pkg.sv */
// Constants shared by both ends of the stack pointer word recognizer link.
// Assumes one system clock and a synchronous active-high reset in each end.
// Summary of operation
// RL1: Config write 80 drives pointer load low
// RL2: Clock-enable port write 00 permits pointer steps
// RL3: Load mode step loads low load-bus nibble
// RL4: Control write stores load-bus high nibble
// RL5: Control RAM holds sixteen 4-bit entries
// RL6: Control RAM outputs read inverted
// RL7: Control RAM readable at control_ram_readback_port
// RL8: Config write 90 selects count mode
// RL9: Count mode step increments when bit0 set
// RL10: Counting walks pointer from 0 to F
// RL11: Pointer reads at port 04, bits 5:2
// RL12: Sequence recognizer uses three 4096x1 RAMs
// RL13: Pointer selects sequence level, sixteen levels
// RL14: Sequence match is AND of three outputs
// RL15: Qualifier uses three 256x4 RAMs, pointer-free
// RL16: Qualifier output n is AND of bits n
// RL17: Sequence RAM at 0E, qualifier at 07
// RL18: Controller writes all, verifies, halts mismatch
// RL19: Controller checks pointer after each step
// RL20: Control RAM ignores low load-bus nibble
// RL21: Sequence readback top bits, reversed order
// RL22: Pointer wraps from F to zero
package spwr_pkg;
   // ------------------------------------------------------------------
   // Port addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] SPWR_PORT_PTR_RD   = 8'h04;
   localparam logic [7:0] SPWR_PORT_QUAL_RD  = 8'h07;
   localparam logic [7:0] SPWR_PORT_CTRL_RD  = 8'h0A;
   localparam logic [7:0] SPWR_PORT_SEQ_RD   = 8'h0E;
   // ------------------------------------------------------------------
   // Configuration values
   // ------------------------------------------------------------------
   localparam logic [7:0] SPWR_CFG_LOAD      = 8'h80;
   localparam logic [7:0] SPWR_CFG_COUNT     = 8'h90;
   localparam logic [7:0] SPWR_CLKEN_ON      = 8'h00;
   localparam logic [7:0] SPWR_STEP_VALUE    = 8'h00;
   localparam int         SPWR_CFG_LOAD_BIT  = 4;
   // ------------------------------------------------------------------
   // Field positions and widths
   // ------------------------------------------------------------------
   localparam int         SPWR_PTR_W         = 4;
   localparam int         SPWR_PTR_RD_LSB    = 2;
   localparam int         SPWR_CTRL_LSB      = 4;
   localparam int         SPWR_SEQ_RD_LSB    = 5;
   localparam int         SPWR_SEQ_DATA_W    = 8;
   localparam int         SPWR_QUAL_ADDR_W   = 8;
   localparam int         SPWR_QUAL_W        = 4;
   localparam int         SPWR_NRAM          = 3;
   localparam int         SPWR_DATA_W        = 24;
   localparam int         SPWR_NCTRL         = 16;
   localparam logic [3:0] SPWR_PTR_RESET     = 4'h0;
   localparam logic [3:0] SPWR_CTRL_RESET    = 4'h0;
   // ------------------------------------------------------------------
   // Controller test states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      SPWR_IDLE, SPWR_CFG, SPWR_WR_PTR, SPWR_WR_CTL, SPWR_RD_PTR, SPWR_RD_CTL,
      SPWR_CHK_CTL, SPWR_CNT_SET, SPWR_CNT_RD, SPWR_CNT_CHK, SPWR_CNT_STEP,
      SPWR_DONE, SPWR_FAIL
   } spwr_state_t;
endpackage

/* File: spwr_if.sv */
// Link between the mainframe controller end and the recognizer device end.
// Assumes both ends share clk_sys; strobes are one-cycle low pulses.
`timescale 1ns/1ps
interface spwr_if;
   logic [7:0] load_bus;
   logic       cfg_wr;
   logic       clken_wr;
   logic       pointer_step_strobe_n;
   logic       ctrl_ram_write_strobe_n;
   logic       ctrl_ram_read_strobe_n;
   logic       seq_we_n;
   logic       qual_we_n;
   logic       rd_en;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport device (
      input  load_bus, cfg_wr, clken_wr, pointer_step_strobe_n,
             ctrl_ram_write_strobe_n, ctrl_ram_read_strobe_n,
             seq_we_n, qual_we_n, rd_en, rd_addr,
      output rd_data
   );
   modport ctrl (
      output load_bus, cfg_wr, clken_wr, pointer_step_strobe_n,
             ctrl_ram_write_strobe_n, ctrl_ram_read_strobe_n,
             seq_we_n, qual_we_n, rd_en, rd_addr,
      input  rd_data
   );
endinterface

/* File: spwr_device.sv */
// Stack pointer, stack control RAM, sequence and qualifier recognizers.
// Assumes controller strobes are synchronous single-cycle low pulses.
`timescale 1ns/1ps
module spwr_device
   import spwr_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   spwr_if.device                     lnk,
   input  wire logic [SPWR_DATA_W-1:0] logged_data_bits,
   output logic                       sequence_match,
   output logic [SPWR_QUAL_W-1:0]     qualifier_match,
   output logic [SPWR_PTR_W-1:0]      pointer_bits
);
   // ------------------------------------------------------------------
   // Mode control
   // ------------------------------------------------------------------
   logic                   pointer_load_n_reg;
   logic                   clk_en_n_reg;
   logic [3:0]             ctrl_ram [SPWR_NCTRL];
   logic [SPWR_NRAM-1:0]   seq_ram [4096];
   logic [SPWR_QUAL_W-1:0] qual_ram [SPWR_NRAM][256];
   logic [3:0]             ctrl_ram_outputs;
   logic [SPWR_NRAM-1:0]   sequence_match_bits;
   logic [SPWR_QUAL_W-1:0] qual_and;
   logic [11:0]            seq_addr;
   logic [7:0]             rd_next;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pointer_load_n_reg <= 1'b1;
         clk_en_n_reg       <= 1'b1;
      end else begin
         if (lnk.cfg_wr)
            pointer_load_n_reg <= lnk.load_bus[SPWR_CFG_LOAD_BIT]; // RL1 RL8
         if (lnk.clken_wr)
            clk_en_n_reg <= (lnk.load_bus != SPWR_CLKEN_ON); // RL2
      end
   end

   // ------------------------------------------------------------------
   // Stack pointer counter
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pointer_bits <= SPWR_PTR_RESET;
      end else if (!lnk.pointer_step_strobe_n && !clk_en_n_reg) begin // RL2
         if (!pointer_load_n_reg)
            pointer_bits <= lnk.load_bus[SPWR_PTR_W-1:0]; // RL3
         else if (ctrl_ram_outputs[0])
            pointer_bits <= pointer_bits + 4'h1; // RL9 RL10 RL22 RL13
      end
   end

   // ------------------------------------------------------------------
   // Stack control RAM
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < SPWR_NCTRL; i++)
            ctrl_ram[i] <= SPWR_CTRL_RESET;
      end else if (!lnk.ctrl_ram_write_strobe_n) begin
         ctrl_ram[pointer_bits] <= lnk.load_bus[7:SPWR_CTRL_LSB]; // RL4 RL5 RL20
      end
   end

   assign ctrl_ram_outputs = ~ctrl_ram[pointer_bits]; // RL6

   // ------------------------------------------------------------------
   // Sequence recognizer: pointer low address, data high address
   // ------------------------------------------------------------------
   assign seq_addr = {logged_data_bits[SPWR_SEQ_DATA_W-1:0], pointer_bits}; // RL12

   always_ff @(posedge clk_sys) begin
      if (!lnk.seq_we_n)
         seq_ram[seq_addr] <= lnk.load_bus[SPWR_NRAM-1:0];
   end

   assign sequence_match_bits = seq_ram[seq_addr];

   always_ff @(posedge clk_sys) begin
      if (srst)
         sequence_match <= 1'b0;
      else
         sequence_match <= &sequence_match_bits; // RL14
   end

   // ------------------------------------------------------------------
   // Qualifier recognizer: each RAM takes its own data byte
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!lnk.qual_we_n) begin
         for (int r = 0; r < SPWR_NRAM; r++)
            qual_ram[r][logged_data_bits[r*8 +: 8]] <= lnk.load_bus[SPWR_QUAL_W-1:0]; // RL15
      end
   end

   always_comb begin
      qual_and = '1;
      for (int r = 0; r < SPWR_NRAM; r++)
         qual_and = qual_and & qual_ram[r][logged_data_bits[r*8 +: 8]]; // RL16
   end

   always_ff @(posedge clk_sys) begin
      if (srst)
         qualifier_match <= '0;
      else
         qualifier_match <= qual_and;
   end

   // ------------------------------------------------------------------
   // Readback ports
   // ------------------------------------------------------------------
   always_comb begin
      rd_next = 8'h00;
      case (lnk.rd_addr)
         SPWR_PORT_PTR_RD:  rd_next = {2'b00, pointer_bits, 2'b00}; // RL11
         SPWR_PORT_QUAL_RD: rd_next = {4'h0, qual_and}; // RL17
         SPWR_PORT_CTRL_RD: begin
            if (!lnk.ctrl_ram_read_strobe_n)
               rd_next = {4'h0, ctrl_ram_outputs}; // RL7
         end
         SPWR_PORT_SEQ_RD:  rd_next = {sequence_match_bits[0], sequence_match_bits[1],
                                       sequence_match_bits[2], 5'b00000}; // RL17 RL21
         default:           rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst)
         lnk.rd_data <= 8'h00;
      else if (lnk.rd_en)
         lnk.rd_data <= rd_next;
   end
endmodule

/* File: spwr_ctrl.sv */
// Controller end: runs stack control RAM test then count mode test.
// Assumes device answers a read one cycle after rd_en.
`timescale 1ns/1ps
module spwr_ctrl
   import spwr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       srst,
   spwr_if.ctrl            lnk,
   input  wire logic       start,
   output logic            busy,
   output logic            done,
   output logic            error,
   output logic [7:0]      err_port,
   output logic [7:0]      err_expected,
   output logic [7:0]      err_actual
);
   spwr_state_t st_reg;
   logic [3:0]  idx_reg;
   logic [1:0]  pass_reg;
   logic [1:0]  cfg_step_reg;
   logic        wait_reg;
   logic [7:0]  exp;

   function automatic logic [3:0] pattern(input logic [1:0] p, input logic [3:0] a);
      logic [1:0] k;
      k = 2'((p + a) % 3);
      pattern = (k == 2'd0) ? 4'hA : (k == 2'd1) ? 4'h1 : 4'hC;
   endfunction

   always_comb begin
      exp = 8'h00;
      case (st_reg)
         SPWR_CHK_CTL: exp = {4'h0, pattern(pass_reg, idx_reg)};
         SPWR_CNT_CHK: exp = {2'b00, idx_reg, 2'b00};
         default:      exp = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg                      <= SPWR_IDLE;
         idx_reg                     <= 4'h0;
         pass_reg                    <= 2'd0;
         cfg_step_reg                <= 2'd0;
         wait_reg                    <= 1'b0;
         busy                        <= 1'b0;
         done                        <= 1'b0;
         error                       <= 1'b0;
         err_port                    <= 8'h00;
         err_expected                <= 8'h00;
         err_actual                  <= 8'h00;
         lnk.load_bus                <= 8'h00;
         lnk.cfg_wr                  <= 1'b0;
         lnk.clken_wr                <= 1'b0;
         lnk.pointer_step_strobe_n   <= 1'b1;
         lnk.ctrl_ram_write_strobe_n <= 1'b1;
         lnk.ctrl_ram_read_strobe_n  <= 1'b1;
         lnk.seq_we_n                <= 1'b1;
         lnk.qual_we_n               <= 1'b1;
         lnk.rd_en                   <= 1'b0;
         lnk.rd_addr                 <= 8'h00;
      end else begin
         lnk.cfg_wr                  <= 1'b0;
         lnk.clken_wr                <= 1'b0;
         lnk.pointer_step_strobe_n   <= 1'b1;
         lnk.ctrl_ram_write_strobe_n <= 1'b1;
         lnk.ctrl_ram_read_strobe_n  <= 1'b1;
         lnk.rd_en                   <= 1'b0;
         case (st_reg)
            SPWR_IDLE: begin
               if (start) begin
                  busy         <= 1'b1;
                  done         <= 1'b0;
                  error        <= 1'b0;
                  pass_reg     <= 2'd0;
                  idx_reg      <= 4'h0;
                  cfg_step_reg <= 2'd0;
                  st_reg       <= SPWR_CFG;
               end
            end
            SPWR_CFG: begin
               cfg_step_reg <= cfg_step_reg + 2'd1;
               if (cfg_step_reg == 2'd0) begin
                  lnk.load_bus <= SPWR_CFG_LOAD; // RL1
                  lnk.cfg_wr   <= 1'b1;
               end else begin
                  lnk.load_bus <= SPWR_CLKEN_ON; // RL2
                  lnk.clken_wr <= 1'b1;
                  st_reg       <= SPWR_WR_PTR;
               end
            end
            SPWR_WR_PTR, SPWR_RD_PTR: begin
               lnk.load_bus              <= {4'h0, idx_reg}; // RL3
               lnk.pointer_step_strobe_n <= 1'b0;
               st_reg <= (st_reg == SPWR_WR_PTR) ? SPWR_WR_CTL : SPWR_RD_CTL;
            end
            SPWR_WR_CTL: begin
               lnk.load_bus                <= {~pattern(pass_reg, idx_reg), 4'h0}; // RL4
               lnk.ctrl_ram_write_strobe_n <= 1'b0;
               idx_reg <= idx_reg + 4'h1;
               st_reg  <= (idx_reg == 4'hF) ? SPWR_RD_PTR : SPWR_WR_PTR; // RL18
            end
            SPWR_RD_CTL: begin
               lnk.rd_addr                <= SPWR_PORT_CTRL_RD;
               lnk.rd_en                  <= 1'b1;
               lnk.ctrl_ram_read_strobe_n <= 1'b0;
               wait_reg                   <= 1'b1;
               st_reg                     <= SPWR_CHK_CTL;
            end
            SPWR_CHK_CTL: begin
               // Read data lands one cycle after the request is taken
               if (wait_reg) begin
                  wait_reg <= 1'b0;
               end else if (lnk.rd_data != exp) begin
                  err_port <= SPWR_PORT_CTRL_RD; // RL18
                  err_expected <= exp;
                  err_actual   <= lnk.rd_data;
                  st_reg       <= SPWR_FAIL;
               end else if (idx_reg != 4'hF) begin
                  idx_reg <= idx_reg + 4'h1;
                  st_reg  <= SPWR_RD_PTR;
               end else if (pass_reg != 2'd2) begin
                  pass_reg <= pass_reg + 2'd1;
                  idx_reg  <= 4'h0;
                  st_reg   <= SPWR_WR_PTR;
               end else begin
                  idx_reg      <= 4'h0;
                  cfg_step_reg <= 2'd0;
                  st_reg       <= SPWR_CNT_SET;
               end
            end
            SPWR_CNT_SET: begin
               // Zero fill: each write lands at the previous pointer, gap between strobes
               cfg_step_reg <= cfg_step_reg + 2'd1;
               if (cfg_step_reg == 2'd0) begin
                  lnk.load_bus                <= {4'h0, idx_reg};
                  lnk.ctrl_ram_write_strobe_n <= 1'b0;
                  lnk.pointer_step_strobe_n   <= 1'b0;
                  cfg_step_reg                <= 2'd3;
                  idx_reg                     <= idx_reg + 4'h1;
               end else if (cfg_step_reg == 2'd3) begin
                  if (idx_reg == 4'h0)
                     cfg_step_reg <= 2'd1;
               end else if (cfg_step_reg == 2'd1) begin
                  // Last entry written, pointer loaded with 0
                  lnk.load_bus                <= 8'h00;
                  lnk.ctrl_ram_write_strobe_n <= 1'b0;
                  lnk.pointer_step_strobe_n   <= 1'b0;
               end else begin
                  lnk.load_bus <= SPWR_CFG_COUNT; // RL8
                  lnk.cfg_wr   <= 1'b1;
                  idx_reg      <= 4'h0;
                  st_reg       <= SPWR_CNT_RD;
               end
            end
            SPWR_CNT_RD: begin
               lnk.rd_addr <= SPWR_PORT_PTR_RD;
               lnk.rd_en   <= 1'b1;
               wait_reg    <= 1'b1;
               st_reg      <= SPWR_CNT_CHK;
            end
            SPWR_CNT_CHK: begin
               if (wait_reg) begin
                  wait_reg <= 1'b0;
               end else if (lnk.rd_data != exp) begin
                  err_port     <= SPWR_PORT_PTR_RD; // RL19
                  err_expected <= exp;
                  err_actual   <= lnk.rd_data;
                  st_reg       <= SPWR_FAIL;
               end else if (idx_reg == 4'hF) begin
                  st_reg <= SPWR_DONE;
               end else begin
                  st_reg <= SPWR_CNT_STEP;
               end
            end
            SPWR_CNT_STEP: begin
               lnk.load_bus              <= SPWR_STEP_VALUE; // RL9
               lnk.pointer_step_strobe_n <= 1'b0;
               idx_reg                   <= idx_reg + 4'h1;
               st_reg                    <= SPWR_CNT_RD;
            end
            SPWR_DONE: begin
               busy   <= 1'b0;
               done   <= 1'b1;
               st_reg <= SPWR_IDLE;
            end
            SPWR_FAIL: begin
               busy   <= 1'b0;
               error  <= 1'b1;
               st_reg <= SPWR_IDLE;
            end
            default: st_reg <= SPWR_IDLE;
         endcase
      end
   end
endmodule

/* File: spwr_properties.sv */
// Concurrent checks on the controller-to-device link.
// Assumes one clock domain; the bench wires the link signals in by name.
`timescale 1ns/1ps
module spwr_properties
   import spwr_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic [7:0] load_bus,
   input wire logic       cfg_wr,
   input wire logic       clken_wr,
   input wire logic       pointer_step_strobe_n,
   input wire logic       ctrl_ram_write_strobe_n,
   input wire logic       ctrl_ram_read_strobe_n,
   input wire logic       rd_en,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data
);
   logic       load_n_reg;
   logic       clken_reg;
   logic [3:0] ptr_reg;
   logic [3:0] ram_reg [16];
   logic [3:0] ctrl_out;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // ----------------
   // Reference pointer and control RAM
   // ----------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         load_n_reg <= 1'h1;
         clken_reg  <= 1'h0;
      end else begin
         if (cfg_wr) begin
            load_n_reg <= load_bus[SPWR_CFG_LOAD_BIT];
         end
         if (clken_wr) begin
            clken_reg <= (load_bus == SPWR_CLKEN_ON);
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ptr_reg <= SPWR_PTR_RESET;
      end else if (!pointer_step_strobe_n && clken_reg) begin
         if (!load_n_reg) begin
            ptr_reg <= load_bus[3:0];
         end else if (ctrl_out[0]) begin
            ptr_reg <= ptr_reg + 4'h1;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < SPWR_NCTRL; i++) begin
            ram_reg[i] <= SPWR_CTRL_RESET;
         end
      end else if (!ctrl_ram_write_strobe_n) begin
         ram_reg[ptr_reg] <= load_bus[7:4];
      end
   end
   assign ctrl_out = ~ram_reg[ptr_reg];

   // ----------------
   // Link checks
   // ----------------
   a_ptr_readback: assert property (
      rd_en && rd_addr == SPWR_PORT_PTR_RD && pointer_step_strobe_n
      |=> rd_data == {2'h0, $past(ptr_reg), 2'h0}) else $error("pointer readback wrong");
   a_ctrl_readback: assert property (
      rd_en && rd_addr == SPWR_PORT_CTRL_RD && !ctrl_ram_read_strobe_n
      && pointer_step_strobe_n && ctrl_ram_write_strobe_n
      |=> rd_data == {4'h0, $past(ctrl_out)}) else $error("control RAM readback wrong");
   a_ctrl_rd_strobe: assert property (
      rd_en && rd_addr == SPWR_PORT_CTRL_RD |-> !ctrl_ram_read_strobe_n)
      else $error("control read without strobe");
   a_cfg_values: assert property (
      cfg_wr |-> load_bus == SPWR_CFG_LOAD || load_bus == SPWR_CFG_COUNT)
      else $error("bad config value");
   a_clken_value: assert property (clken_wr |-> load_bus == SPWR_CLKEN_ON)
      else $error("bad clock enable value");
   a_step_pulse: assert property (!pointer_step_strobe_n |=> pointer_step_strobe_n)
      else $error("step strobe too long");
   a_write_pulse: assert property (
      $fell(ctrl_ram_write_strobe_n) |=> $rose(ctrl_ram_write_strobe_n))
      else $error("write strobe too long");
   a_rd_stands: assert property (!rd_en |=> $stable(rd_data))
      else $error("read data changed without request");
   c_ctrl_read: cover property (rd_en && rd_addr == SPWR_PORT_CTRL_RD);
   c_load_step: cover property (!pointer_step_strobe_n && !load_n_reg);
   c_count_cfg: cover property (cfg_wr && load_bus == SPWR_CFG_COUNT);
endmodule

/* File: testbench.sv */
// Bench for both ends: a joined pair, a bench-driven device, a controller fed bad reads.
// Assumes package, interface, both ends and spwr_properties are compiled first.
`timescale 1ns/1ps
module testbench;
   import spwr_pkg::*;

   logic        clk_sys  = 1'h0;
   logic        srst     = 1'h1;
   logic        start    = 1'h0;
   logic [23:0] ld_b     = 24'h11225A;
   int          n_errors = 0;
   int          compares = 0;
   int          k;
   logic        done, error, busy_c, done_c, error_c, smatch;
   logic [3:0]  qmatch, pb;
   logic [7:0]  ep_c, ee_c, ea_c;
   // Row: op, load value or port, expected byte, data select
   logic [23:0] rows [41] = '{
      24'h080000, 24'h100000, 24'h20F000, 24'h6043C0,
      24'h305000, 24'h60A0F0, 24'h3A7000, 24'h60A050,
      24'h203000, 24'h60A0F0, 24'h6040C0, 24'h605000,
      24'h202000, 24'h50F000, 24'h503001, 24'h607030,
      24'h607031, 24'h401000, 24'h60E800, 24'h404000,
      24'h60E200, 24'h407000, 24'h700130, 24'h403000,
      24'h60EC00, 24'h700030, 24'h20F000, 24'h300000,
      24'h200000, 24'h310000, 24'h60A0E0, 24'h090000,
      24'h200000, 24'h604000, 24'h300000, 24'h101000,
      24'h200000, 24'h604000, 24'h100000, 24'h200000,
      24'h604040};

   spwr_if lnk_a ();
   spwr_if lnk_b ();
   spwr_if lnk_c ();
   assign lnk_c.rd_data = 8'h00;

   always #2 clk_sys = ~clk_sys;

   spwr_device spwr_device_i (.clk_sys(clk_sys), .srst(srst), .lnk(lnk_a.device),
      .logged_data_bits(24'h000000), .sequence_match(), .qualifier_match(),
      .pointer_bits());
   spwr_ctrl spwr_ctrl_i (.clk_sys(clk_sys), .srst(srst), .lnk(lnk_a.ctrl), .start(start),
      .busy(), .done(done), .error(error), .err_port(), .err_expected(), .err_actual());
   spwr_device spwr_device_b_i (.clk_sys(clk_sys), .srst(srst), .lnk(lnk_b.device),
      .logged_data_bits(ld_b), .sequence_match(smatch), .qualifier_match(qmatch),
      .pointer_bits(pb));
   spwr_ctrl spwr_ctrl_c_i (.clk_sys(clk_sys), .srst(srst), .lnk(lnk_c.ctrl), .start(start),
      .busy(busy_c), .done(done_c), .error(error_c), .err_port(ep_c), .err_expected(ee_c),
      .err_actual(ea_c));
   spwr_properties spwr_properties_i (.clk_sys(clk_sys), .srst(srst),
      .load_bus(lnk_a.load_bus), .cfg_wr(lnk_a.cfg_wr), .clken_wr(lnk_a.clken_wr),
      .pointer_step_strobe_n(lnk_a.pointer_step_strobe_n),
      .ctrl_ram_write_strobe_n(lnk_a.ctrl_ram_write_strobe_n),
      .ctrl_ram_read_strobe_n(lnk_a.ctrl_ram_read_strobe_n), .rd_en(lnk_a.rd_en),
      .rd_addr(lnk_a.rd_addr), .rd_data(lnk_a.rd_data));

   // ----------------
   // Tasks
   // ----------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic idle();
      lnk_b.cfg_wr                  = 1'h0;
      lnk_b.clken_wr                = 1'h0;
      lnk_b.pointer_step_strobe_n   = 1'h1;
      lnk_b.ctrl_ram_write_strobe_n = 1'h1;
      lnk_b.ctrl_ram_read_strobe_n  = 1'h1;
      lnk_b.seq_we_n                = 1'h1;
      lnk_b.qual_we_n               = 1'h1;
      lnk_b.rd_en                   = 1'h0;
   endtask

   task automatic put(input logic [3:0] op, input logic [7:0] d, input logic [7:0] e,
                      input logic s);
      @(posedge clk_sys);
      #1;
      ld_b           = s ? 24'h11445A : 24'h11225A;
      lnk_b.load_bus = d;
      case (op)
         4'h0: lnk_b.cfg_wr = 1'h1;
         4'h1: lnk_b.clken_wr = 1'h1;
         4'h2: lnk_b.pointer_step_strobe_n = 1'h0;
         4'h3: lnk_b.ctrl_ram_write_strobe_n = 1'h0;
         4'h4: lnk_b.seq_we_n = 1'h0;
         4'h5: lnk_b.qual_we_n = 1'h0;
         4'h6: begin
            lnk_b.rd_en                  = 1'h1;
            lnk_b.rd_addr                = d;
            lnk_b.ctrl_ram_read_strobe_n = (d != SPWR_PORT_CTRL_RD);
         end
         default: ;
      endcase
      @(posedge clk_sys);
      #1;
      idle();
      if (op == 4'h7) begin
         @(posedge clk_sys);
         #1;
         chk({3'h0, smatch, qmatch}, e);
      end else if (op == 4'h6) begin
         chk(lnk_b.rd_data, e);
      end
   endtask

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      lnk_b.load_bus = 8'h00;
      lnk_b.rd_addr  = 8'h00;
      idle();
      repeat (16) @(posedge clk_sys);
      #1;
      srst  = 1'h0;
      start = 1'h1;
      @(posedge clk_sys);
      #1;
      start = 1'h0;
      for (k = 0; k < 20000 && !(done === 1'h1 && error_c === 1'h1); k++) begin
         @(posedge clk_sys);
      end
      #1;
      if (k == 20000) begin
         n_errors++;
         $display("ERROR %0t: controller run timed out", $time);
         results();
      end
      chk({6'h00, done, error}, 8'h02);
      chk({5'h00, busy_c, done_c, error_c}, 8'h01);
      chk(ep_c, SPWR_PORT_CTRL_RD);
      chk(ee_c, 8'h0A);
      chk(ea_c, 8'h00);
      foreach (rows[i]) begin
         put(rows[i][23:20], rows[i][19:12], rows[i][11:4], rows[i][0]);
      end
      for (int i = 2; i <= 16; i++) begin
         put(4'h2, 8'h00, 8'h00, 1'h0);
         put(4'h6, SPWR_PORT_PTR_RD, {2'h0, 4'(i), 2'h0}, 1'h0);
         chk({4'h0, pb}, {4'h0, 4'(i)});
      end
      srst = 1'h1;
      repeat (2) @(posedge clk_sys);
      #1;
      srst = 1'h0;
      chk({7'h00, done}, 8'h00);
      put(4'h6, SPWR_PORT_PTR_RD, 8'h00, 1'h0);
      put(4'h6, SPWR_PORT_CTRL_RD, 8'h0F, 1'h0);
      put(4'h2, 8'h00, 8'h00, 1'h0);
      put(4'h6, SPWR_PORT_PTR_RD, 8'h00, 1'h0);
      results();
   end
endmodule
